// >>> common/rcdt_pkg.sv
// Package of register map, reset values, field layouts and types for the timers.
package rcdt_pkg;

	// Register offsets in the device control memory window.
	localparam logic [7:0] ADDR_XFER_LIMIT   = 8'h52;
	localparam logic [7:0] ADDR_LOWER_LIMIT  = 8'h54;
	localparam logic [7:0] ADDR_UPPER_LIMIT  = 8'h56;
	// Offset of the aliased register in classic configuration space.
	localparam logic [7:0] ADDR_CFG_PFA_LIMIT = 8'hEA;

	// Field layouts.
	localparam int XFER_MSB  = 7;
	localparam int XFER_W    = 8;
	localparam int LIMIT_MSB = 11;
	localparam int LIMIT_W   = 12;
	localparam int REG_W     = 16;

	// Reset values.
	localparam logic [XFER_W-1:0]  RST_XFER_LIMIT  = 8'h08;
	localparam logic [LIMIT_W-1:0] RST_LOWER_LIMIT = 12'h07F;
	localparam logic [LIMIT_W-1:0] RST_UPPER_LIMIT = 12'h1C0;

	// Caching modes.
	typedef enum logic [1:0] {
		MODE_NONE  = 2'h0,
		MODE_LIGHT = 2'h1,
		MODE_FULL  = 2'h2,
		MODE_RSVD  = 2'h3
	} rcdt_mode_t;

	// Cache occupancy states, one-hot.
	typedef enum logic [1:0] {
		ST_EMPTY  = 2'h1,
		ST_CACHED = 2'h2
	} rcdt_state_t;

	// Events from the completion buffer and the PCI side, one-cycle pulses.
	typedef struct packed {
		logic cycle_start;
		logic read_hit;
		logic cache_load;
		logic data_returned;
	} rcdt_event_t;

	// Memory window register access request.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [7:0]        addr;
		logic [REG_W-1:0]  wdata;
	} rcdt_mem_req_t;

endpackage : rcdt_pkg

// >>> verilog/rcdt_top.sv
// Read cache discard timers with memory window and configuration alias port.
`timescale 1ns/1ps
module rcdt_top #(
	parameter int IDLE_W  = 12,
	parameter int START_W = 8
) (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_pcie_perst_n,
	input  wire logic                   i_global_reset_input_n,
	input  wire logic                   i_por_n,
	input  wire rcdt_pkg::rcdt_mem_req_t i_mem,
	input  wire logic                   i_cfg_wr,
	input  wire logic                   i_cfg_rd,
	input  wire logic [7:0]             i_cfg_wdata,
	input  wire rcdt_pkg::rcdt_mode_t   i_mode,
	input  wire rcdt_pkg::rcdt_event_t  i_evt,
	output logic [15:0]                 o_mem_rdata,
	output logic                        o_mem_rvalid,
	output logic [15:0]                 o_cfg_rdata,
	output logic                        o_cfg_rvalid,
	output logic                        o_cached,
	output logic                        o_discard,
	output logic                        o_miss_check,
	output logic                        o_prefetch_en
);
	import rcdt_pkg::*;

	// Counters must hold every limit and fit the 16-bit increment helper.
	generate
		if (IDLE_W < LIMIT_W || START_W < XFER_W ||
			IDLE_W > 16 || START_W > 16) begin : g_bad_width
			$error("rcdt_top counter widths outside 12..16 or 8..16");
		end
	endgenerate

	// Saturating increment used by both counters.
	function automatic logic [15:0] sat_inc(input logic [15:0] v,
		input logic [15:0] top);
		sat_inc = (v >= top) ? top : v + 16'h0001;
	endfunction : sat_inc

	logic                 rst_any;
	logic [XFER_W-1:0]    xfer_limit;
	logic [LIMIT_W-1:0]   lower_limit;
	logic [LIMIT_W-1:0]   upper_limit;
	logic [IDLE_W-1:0]    idle_cnt;
	logic [START_W-1:0]   start_cnt;
	rcdt_state_t          state;
	rcdt_state_t          next_state;
	logic                 next_discard;
	logic                 restart;
	logic                 caching;
	logic                 idle_upper;
	logic                 idle_lower;
	logic                 starts_done;
	logic [15:0]          next_mem_rdata;
	logic                 wr_xfer;

	// Any reset source returns the limits to their defaults.
	assign rst_any = !i_reset_n || !i_pcie_perst_n ||
		!i_global_reset_input_n || !i_por_n;

	// Transfer limit: memory window write wins over a same-cycle alias write.
	assign wr_xfer = i_mem.wr && (i_mem.addr == ADDR_XFER_LIMIT);
	always_ff @(posedge i_core_clk) begin
		if (rst_any) begin
			xfer_limit <= RST_XFER_LIMIT;
		end else if (wr_xfer) begin
			xfer_limit <= i_mem.wdata[XFER_MSB:0];
		end else if (i_cfg_wr) begin
			xfer_limit <= i_cfg_wdata;
		end
	end

	// Lower and upper idle limits keep only their twelve field bits.
	always_ff @(posedge i_core_clk) begin
		if (rst_any) begin
			lower_limit <= RST_LOWER_LIMIT;
			upper_limit <= RST_UPPER_LIMIT;
		end else if (i_mem.wr) begin
			if (i_mem.addr == ADDR_LOWER_LIMIT) begin
				lower_limit <= i_mem.wdata[LIMIT_MSB:0];
			end
			if (i_mem.addr == ADDR_UPPER_LIMIT) begin
				upper_limit <= i_mem.wdata[LIMIT_MSB:0];
			end
		end
	end

	// Read mux: reserved bits zero, unmapped offsets read zero.
	always_comb begin
		next_mem_rdata = 16'h0000;
		case (i_mem.addr)
			ADDR_XFER_LIMIT: begin
				next_mem_rdata = {8'h00, xfer_limit};
			end
			ADDR_LOWER_LIMIT: begin
				next_mem_rdata = {4'h0, lower_limit};
			end
			ADDR_UPPER_LIMIT: begin
				next_mem_rdata = {4'h0, upper_limit};
			end
			default: begin
				next_mem_rdata = 16'h0000;
			end
		endcase
	end

	// Read data is registered and valid one cycle after the strobe.
	always_ff @(posedge i_core_clk) begin
		if (rst_any) begin
			o_mem_rdata  <= 16'h0000;
			o_mem_rvalid <= 1'b0;
			o_cfg_rdata  <= 16'h0000;
			o_cfg_rvalid <= 1'b0;
		end else begin
			o_mem_rvalid <= i_mem.rd;
			o_cfg_rvalid <= i_cfg_rd;
			if (i_mem.rd) begin
				o_mem_rdata <= next_mem_rdata;
			end
			if (i_cfg_rd) begin
				o_cfg_rdata <= {8'h00, xfer_limit};
			end
		end
	end

	// Condition decode for the discard decision.
	assign caching     = (i_mode == MODE_LIGHT) || (i_mode == MODE_FULL);
	assign idle_upper  = idle_cnt >= IDLE_W'(upper_limit);
	assign idle_lower  = idle_cnt >= IDLE_W'(lower_limit);
	assign starts_done = start_cnt >= START_W'(xfer_limit);
	assign restart     = i_evt.read_hit || i_evt.cache_load ||
		next_discard;

	// Discard decision and occupancy next state.
	always_comb begin
		next_discard = 1'b0;
		next_state   = state;
		case (state)
			ST_EMPTY: begin
				if (i_evt.cache_load) begin
					next_state = ST_CACHED;
				end
			end
			ST_CACHED: begin
				if (!caching) begin
					next_discard = i_evt.data_returned;
				end else if (!i_evt.read_hit) begin
					next_discard = idle_upper ||
						(idle_lower && starts_done);
				end
				if (next_discard && !i_evt.cache_load) begin
					next_state = ST_EMPTY;
				end
			end
			default: begin
				next_state = ST_EMPTY;
			end
		endcase
	end

	// Occupancy state and registered status outputs.
	always_ff @(posedge i_core_clk) begin
		if (rst_any) begin
			state         <= ST_EMPTY;
			o_cached      <= 1'b0;
			o_discard     <= 1'b0;
			o_miss_check  <= 1'b0;
			o_prefetch_en <= 1'b0;
		end else begin
			state         <= next_state;
			o_cached      <= next_state == ST_CACHED;
			o_discard     <= next_discard;
			o_miss_check  <= (state == ST_CACHED) && idle_lower;
			o_prefetch_en <= caching;
		end
	end

	// Idle clock counter; restarts on hit, load or discard.
	always_ff @(posedge i_core_clk) begin
		if (rst_any || restart) begin
			idle_cnt <= '0;
		end else if (state == ST_CACHED) begin
			idle_cnt <= IDLE_W'(sat_inc(16'(idle_cnt),
				16'((1 << IDLE_W) - 1)));
		end
	end

	// Cycle-start counter counts starts that brought no hit.
	always_ff @(posedge i_core_clk) begin
		if (rst_any || restart) begin
			start_cnt <= '0;
		end else if (state == ST_CACHED && i_evt.cycle_start) begin
			start_cnt <= START_W'(sat_inc(16'(start_cnt),
				16'((1 << START_W) - 1)));
		end
	end

	// Reset values are seen right after any reset source.
	AST_XFER_RESET: assert property (@(posedge i_core_clk)
		rst_any |=> xfer_limit == RST_XFER_LIMIT)
		else $error("transfer limit not eight after reset");
	AST_LOWER_RESET: assert property (@(posedge i_core_clk)
		!i_por_n |=> lower_limit == RST_LOWER_LIMIT)
		else $error("lower limit not 127 after reset");
	AST_UPPER_RESET: assert property (@(posedge i_core_clk)
		!i_global_reset_input_n |=> upper_limit == RST_UPPER_LIMIT)
		else $error("upper limit not 448 after reset");
	AST_ANY_RESET: assert property (@(posedge i_core_clk)
		!i_pcie_perst_n |=> (lower_limit == RST_LOWER_LIMIT &&
		upper_limit == RST_UPPER_LIMIT && xfer_limit == RST_XFER_LIMIT))
		else $error("fundamental reset missed a limit");

	// Reserved bits read as zero.
	AST_XFER_RSVD: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mem.rd && i_mem.addr == ADDR_XFER_LIMIT) |=>
		o_mem_rdata[15:8] == 8'h00)
		else $error("transfer limit upper byte not zero");
	AST_LIMIT_RSVD: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mem.rd && (i_mem.addr == ADDR_LOWER_LIMIT ||
		i_mem.addr == ADDR_UPPER_LIMIT)) |=> o_mem_rdata[15:12] == 4'h0)
		else $error("limit reserved nibble not zero");

	// Alias write is visible through the memory window.
	AST_ALIAS: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_cfg_wr && !wr_xfer) |=> xfer_limit == $past(i_cfg_wdata))
		else $error("alias write not seen in memory window");
	AST_DECODE: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mem.wr && i_mem.addr == ADDR_UPPER_LIMIT) |=>
		upper_limit == $past(i_mem.wdata[LIMIT_MSB:0]))
		else $error("upper limit write not decoded");

	// Cached data survives while no limit is reached.
	AST_KEEP: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_CACHED && caching && !starts_done && !idle_upper)
		|=> !o_discard)
		else $error("cached data dropped before limits");
	AST_UPPER: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_CACHED && caching && idle_upper && !i_evt.read_hit)
		|=> o_discard ##1 !o_discard)
		else $error("upper idle limit did not discard");
	AST_LOWER: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_CACHED && caching && !idle_lower && !idle_upper)
		|=> !o_discard && !o_miss_check)
		else $error("miss check before lower limit");
	AST_NOCACHE: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_CACHED && i_mode == MODE_NONE &&
		i_evt.data_returned) |=> (o_discard && !o_prefetch_en))
		else $error("no-caching mode kept data");
	AST_RESTART: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_evt.read_hit || i_evt.cache_load) |=>
		(idle_cnt == '0 && start_cnt == '0))
		else $error("counters did not restart");

	// Read strobes on both paths are answered one cycle later.
	AST_RVALID: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		i_mem.rd |=> o_mem_rvalid)
		else $error("memory read not answered");
	AST_LOWER_READ: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mem.rd && i_mem.addr == ADDR_LOWER_LIMIT) |=>
		o_mem_rdata[LIMIT_MSB:0] == $past(lower_limit))
		else $error("lower limit read wrong");
	AST_CFG_READ: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		i_cfg_rd |=> (o_cfg_rvalid &&
		o_cfg_rdata == {8'h00, $past(xfer_limit)}))
		else $error("alias read wrong");

	// Prefetch enable follows the caching mode.
	AST_PF_OFF: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mode == MODE_NONE || i_mode == MODE_RSVD) |=> !o_prefetch_en)
		else $error("prefetch on without caching");
	AST_PF_ON: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(i_mode == MODE_LIGHT || i_mode == MODE_FULL) |=> o_prefetch_en)
		else $error("prefetch off while caching");

	// A discard empties the cache unless a fresh load arrives with it.
	AST_DISCARD_EMPTY: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(next_discard && !i_evt.cache_load) |=> (o_discard && !o_cached))
		else $error("discard left data cached");
	AST_EMPTY_QUIET: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_EMPTY) |=> !o_discard)
		else $error("discard while nothing cached");

	// Miss check and cycle-start counting follow their conditions.
	AST_MISS_SET: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(state == ST_CACHED && idle_lower) |=> o_miss_check)
		else $error("miss check not raised after lower limit");
	AST_START_HOLD: assert property (@(posedge i_core_clk)
		disable iff (rst_any)
		(!i_evt.cycle_start && !restart) |=> $stable(start_cnt))
		else $error("start counter moved without a cycle start");

endmodule : rcdt_top

// >>> test/rcdt_pci_master.sv
// PCI master model issuing cycle starts, read hits and data returns.
`timescale 1ns/1ps
module rcdt_pci_master (
	input  wire logic i_core_clk,
	input  wire logic i_run,
	input  wire logic i_hit,
	input  wire logic i_ret,
	output logic      o_cycle_start = 1'b0,
	output logic      o_read_hit = 1'b0,
	output logic      o_data_returned = 1'b0
);
	// Events move on the falling edge so the bridge samples settled lines.
	always @(negedge i_core_clk) begin
		o_cycle_start   <= i_run;
		o_read_hit      <= i_hit;
		o_data_returned <= i_ret;
	end
endmodule : rcdt_pci_master

// >>> test/test_read_cache_discard_timers.sv
// Self-checking bench for the read cache discard timers.
`timescale 1ns/1ps
module test_read_cache_discard_timers;
	import rcdt_pkg::*;
	logic          clk = 0, rst_n = 0, perst_n = 1, global_reset_input_n = 1, por_n = 1;
	rcdt_mem_req_t mem = '0;
	logic          cfg_wr = 0, cfg_rd = 0, load = 0, run = 0, hit = 0, ret = 0;
	logic [7:0]    cfg_wd = 8'h00;
	rcdt_mode_t    mode = MODE_FULL;
	logic          cs, rh, dr, mrv, crv, cached, disc, miss, pf;
	logic [15:0]   mrd, crd, r;
	int            failures = 0, checks_done = 0, n, k, miss_at;
	logic [7:0]    adr [3] = '{8'h52, 8'h54, 8'h56};
	logic [15:0]   rv [3] = '{16'h0008, 16'h007F, 16'h01C0};
	logic [15:0]   msk [3] = '{16'h00FF, 16'h0FFF, 16'h0FFF};
	logic [15:0]   w;

	always #5 clk = ~clk;

	rcdt_pci_master u_pci (.i_core_clk(clk), .i_run(run), .i_hit(hit),
		.i_ret(ret), .o_cycle_start(cs), .o_read_hit(rh),
		.o_data_returned(dr));

	rcdt_top u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_pcie_perst_n(perst_n), .i_global_reset_input_n(global_reset_input_n),
		.i_por_n(por_n), .i_mem(mem), .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd),
		.i_cfg_wdata(cfg_wd), .i_mode(mode), .i_evt({cs, rh, load, dr}),
		.o_mem_rdata(mrd), .o_mem_rvalid(mrv), .o_cfg_rdata(crd),
		.o_cfg_rvalid(crv), .o_cached(cached), .o_discard(disc),
		.o_miss_check(miss), .o_prefetch_en(pf));

	task automatic check(input string nm, input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk) mem <= '{1'b1, 1'b0, a, d};
		@(negedge clk) mem.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk) mem <= '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clk) mem.rd <= 1'b0;
		for (int i = 0; i < 4 && mrv !== 1'b1; i++) @(negedge clk);
		check("read valid", mrv, 16'h0001);
		d = mrd;
	endtask : rd

	// Loads the cache, then counts cycles until the discard pulse.
	task automatic timed(input int hit_at, ret_at, output int c);
		@(negedge clk) load <= 1'b1;
		@(negedge clk) load <= 1'b0;
		check("cached on load", cached, 16'h0001);
		c = 0;
		miss_at = -1;
		while (disc !== 1'b1 && c < 5000) begin
			if (miss === 1'b1 && miss_at < 0) miss_at = c;
			hit <= (c == hit_at);
			ret <= (c == ret_at);
			@(negedge clk);
			c++;
		end
		if (miss === 1'b1 && miss_at < 0) miss_at = c;
		hit <= 1'b0;
		ret <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : timed

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	initial begin
		#400000;
		failures++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h9a66));
		repeat (10) @(negedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(adr[i], r);
			check("reset value", r, rv[i]);
			w = $urandom;
			wr(adr[i], w);
			rd(adr[i], r);
			check("masked write", r, w & msk[i]);
		end
		rd(8'h58, r);
		check("unmapped", r, 16'h0000);
		$display("register map test done");
		w = $urandom;
		@(negedge clk) {cfg_wr, cfg_wd} <= {1'b1, w[7:0]};
		@(negedge clk) cfg_wr <= 1'b0;
		rd(8'h52, r);
		check("alias to window", r, {8'h00, w[7:0]});
		wr(8'h52, 16'hAB5C);
		@(negedge clk) cfg_rd <= 1'b1;
		@(negedge clk) cfg_rd <= 1'b0;
		for (int i = 0; i < 4 && crv !== 1'b1; i++) @(negedge clk);
		check("config valid", crv, 16'h0001);
		check("alias to config", crd, 16'h005C);
		$display("alias test done");
		for (k = 0; k < 3; k++) begin
			for (int i = 0; i < 3; i++) wr(adr[i], 16'h0005);
			@(negedge clk) {perst_n, global_reset_input_n, por_n} <= ~(3'b100 >> k);
			@(negedge clk) {perst_n, global_reset_input_n, por_n} <= 3'b111;
			for (int i = 0; i < 3; i++) begin
				rd(adr[i], r);
				check("source reset", r, rv[i]);
			end
		end
		$display("reset source test done");
		for (k = 0; k < 4; k++) begin
			@(negedge clk) mode <= rcdt_mode_t'(k);
			repeat (2) @(negedge clk);
			check("prefetch", pf, (k == 1 || k == 2));
		end
		$display("mode test done");
		mode <= MODE_FULL;
		w = $urandom_range(20, 8);
		wr(8'h56, w);
		wr(8'h54, 16'h0002);
		wr(8'h52, 16'h00FF);
		timed(-1, -1, n);
		check("upper span", n >= w && n <= w + 4, 1);
		check("miss after lower", miss_at >= 2 && miss_at <= 6, 1);
		check("cached after", cached, 0);
		timed(5, -1, n);
		check("hit restart", n >= w + 5 && n <= w + 10, 1);
		$display("upper limit test done");
		wr(8'h56, 16'h0FFF);
		run <= 1'b1;
		mode <= MODE_LIGHT;
		w = $urandom_range(14, 6);
		wr(8'h52, w);
		timed(-1, -1, n);
		check("start count", n >= w && n <= w + 4, 1);
		wr(8'h52, 16'h0002);
		wr(8'h54, 16'h001E);
		timed(-1, -1, n);
		check("lower span", n >= 30 && n <= 34, 1);
		check("miss at lower", miss_at >= 30 && miss_at <= 34, 1);
		run <= 1'b0;
		$display("miss limit test done");
		wr(8'h56, 16'h0008);
		mode <= MODE_NONE;
		timed(-1, 15, n);
		check("no cache", n >= 15 && n <= 19, 1);
		$display("no caching test done");
		print_verdict();
	end
endmodule : test_read_cache_discard_timers
